// ==== ascp_pkg.sv ====
// constants for the serial control port of the sampling converter
// assumes a 20 MHz system clock; all link pins are asynchronous to it
package ascp_pkg;
  // control word layout
  localparam int          CW_W        = 10;   // control word width
  localparam int          ADDR_BIT    = 8;    // package address bit
  localparam int          PD_HI_BIT   = 7;    // power_down_select_hi
  localparam int          PD_LO_BIT   = 6;    // power_down_select_lo
  localparam int          SWCONV_BIT  = 1;    // software conversion start
  localparam logic [9:0]  CW_RESET    = 10'h000;
  // serial counts
  localparam logic [3:0]  WR_BITS     = 4'hA; // bits captured per write
  localparam logic [3:0]  RD_BITS     = 4'hA; // bits shifted per read
  localparam logic [3:0]  CNT_ZERO    = 4'h0;
  localparam logic [3:0]  CNT_ONE     = 4'h1;
  // power-down select codes
  localparam logic [1:0]  PD_FULL_NOW = 2'h0;
  localparam logic [1:0]  PD_PART_EOC = 2'h1;
  localparam logic [1:0]  PD_FULL_EOC = 2'h2;
  localparam logic [1:0]  PD_UP       = 2'h3;
  // conversion timing
  localparam int          CLK_NS      = 50;
  localparam int          CONV_NS     = 2300; // longest conversion time
  localparam int          CONV_CYC_I  = (CONV_NS / CLK_NS < 1) ? 1 : CONV_NS / CLK_NS;
  localparam logic [7:0]  CONV_CYC    = 8'(CONV_CYC_I);
  localparam logic [7:0]  CONV_ONE    = 8'h01;
  // wishbone register map (byte addresses)
  localparam logic [7:0]  REG_STATUS  = 8'h00;
  localparam logic [7:0]  REG_CONFIG  = 8'h04;
  localparam logic [7:0]  REG_SWCTRL  = 8'h08;
  localparam int          SW_CONV_BIT = 0;
  // result buffer
  localparam int          BUF_DEPTH   = 2;
  // power state of the converter
  typedef enum logic [1:0] {PWR_FULL, PWR_PARTIAL, PWR_UP} ascp_pwr_t;
endpackage : ascp_pkg

// ==== ascp_buf_if.sv ====
// carrier between the control port core and its result buffer
// assumes one clock domain shared by both ends
`timescale 1ns/100ps
interface ascp_buf_if;
  logic       push_valid; // conversion result offered
  logic       push_ready; // buffer has a free slot
  logic [9:0] push_data;  // result word in
  logic       pop_valid;  // a result is waiting
  logic       pop_ready;  // reader takes the head
  logic [9:0] pop_data;   // head result word
  modport core (output push_valid, push_data, pop_ready,
                input  push_ready, pop_valid, pop_data);
  modport fifo (input  push_valid, push_data, pop_ready,
                output push_ready, pop_valid, pop_data);
endinterface : ascp_buf_if

// ==== ascp_buf.sv ====
// two-entry result buffer between conversion end and serial read
// assumes synchronous active-high reset on the same clock as the core
`timescale 1ns/100ps
module ascp_buf (
  input  wire logic clk_i,
  input  wire logic rst_i,
  ascp_buf_if.fifo  bus
);
  logic [9:0] mem_reg [ascp_pkg::BUF_DEPTH]; // storage slots
  logic       wp_reg, wp_next;                // write pointer
  logic       rp_reg, rp_next;                // read pointer
  logic [1:0] cnt_reg, cnt_next;              // fill level
  logic       do_push, do_pop;

  // honest flags straight from the fill level
  assign bus.push_ready = (cnt_reg != 2'(ascp_pkg::BUF_DEPTH));
  assign bus.pop_valid  = (cnt_reg != 2'h0);
  assign bus.pop_data   = mem_reg[rp_reg];
  assign do_push        = bus.push_valid && bus.push_ready;
  assign do_pop         = bus.pop_valid && bus.pop_ready;

  // pointer and level update
  always_comb
  begin
    wp_next  = do_push ? ~wp_reg : wp_reg;
    rp_next  = do_pop ? ~rp_reg : rp_reg;
    cnt_next = cnt_reg + 2'(do_push) - 2'(do_pop);
  end

  // registers; storage itself needs no reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end
    else
    begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
    if (do_push)
      mem_reg[wp_reg] <= bus.push_data;
  end
endmodule : ascp_buf

// ==== ascp_top.sv ====
// serial control port and conversion-start logic of a 10-bit sampling converter
// assumes link pins asynchronous to clk_i; serial clock made by the host
// Overview of operation
// - control frame fall starts ten-bit shift in
// - read frame rise enables read counter
// - ignore serial clock for reads until frame
// - read counter resets when read finishes
// - output bit changes on serial clock rise
// - output released at eleventh rising edge
// - keep first ten written bits only
// - input sampled on serial clock fall
// - trigger fall holds sample, starts conversion
// - trigger level at end decides power-down
// - address pin pairs with word address bit
// - mismatched address word is discarded
// - control word resets to zero, powered down
// - power-down select codes 00,01,10,11
`timescale 1ns/100ps
module ascp_top (
  input  wire logic        clk_i,         // 20 MHz system clock
  input  wire logic        rst_i,         // synchronous reset
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // serial link pins
  input  wire logic        sclk_i,        // serial clock from host
  input  wire logic        control_frame_sync_i,
  input  wire logic        read_frame_sync_i,
  input  wire logic        sdi_i,         // serial data in
  input  wire logic        conversion_trigger_i,
  input  wire logic        package_address_select_i,
  output logic             sdo_o,         // serial data out
  output logic             sdo_oe_n_o,    // low while sdo_o drives the pin
  // converter core side
  input  wire logic [9:0]  adc_result_i,  // result valid at end of conversion
  output logic [9:0]       ctrl_word_o,   // accepted control word
  output logic [1:0]       pwr_state_o,   // ascp_pwr_t code
  output logic             hold_o         // track/hold in hold
);
  // pin synchronisers: stage 1 only feeds stage 2, stage 3 for edges
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] pin_w;
  logic [NSYNC-1:0] s1_reg, s2_reg, s3_reg;
  logic sclk_rise, sclk_fall, cfs_fall, rfs_rise, trig_fall, trig_lvl, sdi_s, addr_pin;

  assign pin_w = {package_address_select_i, conversion_trigger_i, sdi_i,
                  read_frame_sync_i, control_frame_sync_i, sclk_i};

  // three-stage register chain, reset loads constant zeros
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end
    else
    begin
      s1_reg <= pin_w;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // edge detection on synchronised levels only
  assign sclk_rise = s2_reg[0] && !s3_reg[0];
  assign sclk_fall = !s2_reg[0] && s3_reg[0];
  assign cfs_fall  = !s2_reg[1] && s3_reg[1];
  assign rfs_rise  = s2_reg[2] && !s3_reg[2];
  assign sdi_s     = s2_reg[3];
  assign trig_fall = !s2_reg[4] && s3_reg[4];
  assign trig_lvl  = s2_reg[4];
  assign addr_pin  = s2_reg[5];

  // buffer between conversion end and the serial reader
  ascp_buf_if bq ();
  ascp_buf u_buf (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .bus   (bq.fifo)
  );

  // ---------------- serial write path ----------------
  logic       wr_act_reg, wr_act_next;   // write frame open
  logic [3:0] wr_cnt_reg, wr_cnt_next;   // bits captured so far
  logic [9:0] wr_sh_reg,  wr_sh_next;    // incoming shift register
  logic [9:0] cw_reg,     cw_next;       // accepted control word
  logic       sel_reg,    sel_next;      // this device owns next read
  logic       accept;                    // tenth bit with matching address
  logic [9:0] word_in;                   // word as completed this cycle

  localparam logic [3:0] CNT_ONE_W = ascp_pkg::CNT_ONE;
  assign word_in = {wr_sh_reg[8:0], sdi_s};
  assign accept  = wr_act_reg && sclk_fall && (wr_cnt_reg == ascp_pkg::WR_BITS - CNT_ONE_W)
                   && (word_in[ascp_pkg::ADDR_BIT] == addr_pin);

  // capture, address check and word update
  always_comb
  begin
    wr_act_next = wr_act_reg;
    wr_cnt_next = wr_cnt_reg;
    wr_sh_next  = wr_sh_reg;
    cw_next     = cw_reg;
    sel_next    = sel_reg;
    if (cfs_fall)
    begin
      wr_act_next = 1'b1;
      wr_cnt_next = ascp_pkg::CNT_ZERO;
    end
    else if (wr_act_reg && sclk_fall)
    begin
      wr_sh_next  = word_in;
      wr_cnt_next = wr_cnt_reg + CNT_ONE_W;
      if (wr_cnt_reg == ascp_pkg::WR_BITS - CNT_ONE_W)
      begin
        // later clocks of the frame fall through, host may send 13
        wr_act_next = 1'b0;
        sel_next    = accept;
        if (accept)
          cw_next = word_in;
      end
    end
  end

  // write path registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_act_reg <= 1'b0;
      wr_cnt_reg <= ascp_pkg::CNT_ZERO;
      wr_sh_reg  <= ascp_pkg::CW_RESET;
      cw_reg     <= ascp_pkg::CW_RESET;
      sel_reg    <= 1'b1;                           // address bit 0 at power-up
    end
    else
    begin
      wr_act_reg <= wr_act_next;
      wr_cnt_reg <= wr_cnt_next;
      wr_sh_reg  <= wr_sh_next;
      cw_reg     <= cw_next;
      sel_reg    <= sel_next;
    end
  end

  // ---------------- serial read path ----------------
  logic       rd_act_reg, rd_act_next;   // read counter enabled
  logic [3:0] rd_cnt_reg, rd_cnt_next;   // rising edges seen
  logic [9:0] rd_sh_reg,  rd_sh_next;    // outgoing shift register
  logic       sdo_reg,    sdo_next;
  logic       oen_reg,    oen_next;

  // the head of the buffer is taken by a selected read frame
  assign bq.pop_ready = rfs_rise && sel_reg;

  // counter, shifter and pin drive
  always_comb
  begin
    rd_act_next = rd_act_reg;
    rd_cnt_next = rd_cnt_reg;
    rd_sh_next  = rd_sh_reg;
    sdo_next    = sdo_reg;
    oen_next    = oen_reg;
    if (rfs_rise && sel_reg)
    begin
      // empty buffer reads as zeros rather than stale data
      rd_act_next = 1'b1;
      rd_cnt_next = ascp_pkg::CNT_ZERO;
      rd_sh_next  = bq.pop_valid ? bq.pop_data : ascp_pkg::CW_RESET;
    end
    else if (rd_act_reg && sclk_rise)
    begin
      if (rd_cnt_reg == ascp_pkg::RD_BITS)
      begin
        oen_next    = 1'b1;
        rd_act_next = 1'b0;
        rd_cnt_next = ascp_pkg::CNT_ZERO;
      end
      else
      begin
        sdo_next    = rd_sh_reg[9];
        rd_sh_next  = {rd_sh_reg[8:0], 1'b0};
        oen_next    = 1'b0;
        rd_cnt_next = rd_cnt_reg + CNT_ONE_W;
      end
    end
  end

  // read path registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_act_reg <= 1'b0;
      rd_cnt_reg <= ascp_pkg::CNT_ZERO;
      rd_sh_reg  <= ascp_pkg::CW_RESET;
      sdo_reg    <= 1'b0;
      oen_reg    <= 1'b1;
    end
    else
    begin
      rd_act_reg <= rd_act_next;
      rd_cnt_reg <= rd_cnt_next;
      rd_sh_reg  <= rd_sh_next;
      sdo_reg    <= sdo_next;
      oen_reg    <= oen_next;
    end
  end

  // ---------------- conversion and power ----------------
  ascp_pkg::ascp_pwr_t pwr_reg, pwr_next;
  logic       busy_reg,  busy_next;          // conversion running
  logic [7:0] ccnt_reg,  ccnt_next;          // cycles into conversion
  logic       sw_go;                         // software start from the bus
  logic       start, eoc;
  logic [1:0] pd_sel;

  assign pd_sel = {cw_reg[ascp_pkg::PD_HI_BIT], cw_reg[ascp_pkg::PD_LO_BIT]};
  // a start is dropped while the buffer is full, so no result is lost
  assign start  = (trig_fall || sw_go || (accept && word_in[ascp_pkg::SWCONV_BIT]))
                  && !busy_reg && bq.push_ready;
  assign eoc    = busy_reg && (ccnt_reg == ascp_pkg::CONV_CYC);
  assign bq.push_valid = eoc;
  assign bq.push_data  = adc_result_i;

  // conversion timer and power decision
  always_comb
  begin
    busy_next = busy_reg;
    ccnt_next = ccnt_reg;
    pwr_next  = pwr_reg;
    if (start)
    begin
      busy_next = 1'b1;
      ccnt_next = ascp_pkg::CONV_ONE;
      pwr_next  = ascp_pkg::PWR_UP;
    end
    else if (eoc)
    begin
      busy_next = 1'b0;
      unique case (pd_sel)
        ascp_pkg::PD_UP:       pwr_next = ascp_pkg::PWR_UP;
        ascp_pkg::PD_FULL_NOW: pwr_next = ascp_pkg::PWR_FULL;
        ascp_pkg::PD_PART_EOC: pwr_next = trig_lvl ? ascp_pkg::PWR_UP
                                                   : ascp_pkg::PWR_PARTIAL;
        ascp_pkg::PD_FULL_EOC: pwr_next = trig_lvl ? ascp_pkg::PWR_UP
                                                   : ascp_pkg::PWR_FULL;
      endcase
    end
    else if (busy_reg)
      ccnt_next = ccnt_reg + ascp_pkg::CONV_ONE;
    else if (pd_sel == ascp_pkg::PD_FULL_NOW)
      pwr_next = ascp_pkg::PWR_FULL;
    else if (pd_sel == ascp_pkg::PD_UP)
      pwr_next = ascp_pkg::PWR_UP;
  end

  // conversion registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy_reg <= 1'b0;
      ccnt_reg <= 8'h00;
      pwr_reg  <= ascp_pkg::PWR_FULL;
    end
    else
    begin
      busy_reg <= busy_next;
      ccnt_reg <= ccnt_next;
      pwr_reg  <= pwr_next;
    end
  end

  // ---------------- wishbone slave ----------------
  logic        ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic        wb_req;

  assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign sw_go  = wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == ascp_pkg::REG_SWCTRL)
                  && wb_dat_i[ascp_pkg::SW_CONV_BIT];

  // one wait state, unmapped reads return zero
  always_comb
  begin
    ack_next  = wb_req;
    rdat_next = rdat_reg;
    if (wb_req && !wb_we_i)
    begin
      unique case (wb_adr_i)
        ascp_pkg::REG_STATUS: rdat_next = {25'h0, bq.pop_valid, !bq.push_ready,
                                           rd_act_reg, sel_reg, busy_reg, pwr_reg};
        ascp_pkg::REG_CONFIG: rdat_next = {22'h0, cw_reg};
        default:              rdat_next = 32'h0000_0000;
      endcase
    end
  end

  // bus registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg  <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  assign wb_ack_o    = ack_reg;
  assign wb_dat_o    = rdat_reg;
  assign sdo_o       = sdo_reg;
  assign sdo_oe_n_o  = oen_reg;
  assign ctrl_word_o = cw_reg;
  assign pwr_state_o = pwr_reg;
  assign hold_o      = busy_reg;

  // ---------------- checks ----------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence last_rise_s;
    rd_act_reg && sclk_rise && (rd_cnt_reg == ascp_pkg::RD_BITS);
  endsequence
  sequence released_s;
    oen_reg && !rd_act_reg && (rd_cnt_reg == ascp_pkg::CNT_ZERO);
  endsequence

  wr_count_cap_a: assert property (wr_cnt_reg <= ascp_pkg::WR_BITS)
    else $error("write bit count beyond ten");
  word_match_a: assert property (cw_reg != $past(cw_reg) |->
      $past(sclk_fall) && $past(word_in[ascp_pkg::ADDR_BIT]) == $past(addr_pin))
    else $error("control word changed without address match");
  cfs_open_a: assert property (cfs_fall |=> wr_act_reg && wr_cnt_reg == 4'h0)
    else $error("control frame did not open write");
  drive_gate_a: assert property (!oen_reg |-> rd_act_reg || $past(rd_act_reg))
    else $error("data driven outside a read");
  release_seq_a: assert property (last_rise_s |=> released_s)
    else $error("output not released on eleventh rise");
  shift_msb_a: assert property (rd_act_reg && sclk_rise && rd_cnt_reg < ascp_pkg::RD_BITS
      |=> sdo_reg == $past(rd_sh_reg[9]) && !oen_reg)
    else $error("output bit not shifted on rise");
  conv_len_a: assert property ($rose(busy_reg) |-> hold_o ##0
      (busy_reg && !eoc)[*8])
    else $error("conversion shorter than expected");
  pd_now_a: assert property (pd_sel == ascp_pkg::PD_FULL_NOW && !busy_reg && !start
      |=> pwr_reg == ascp_pkg::PWR_FULL)
    else $error("full power-down not immediate");
  eoc_pd_a: assert property (eoc && !start && !trig_lvl && pd_sel == ascp_pkg::PD_PART_EOC
      |=> pwr_reg == ascp_pkg::PWR_PARTIAL)
    else $error("partial power-down missed at end");
  reset_word_a: assert property (disable iff (1'b0) $past(rst_i) |-> cw_reg == 10'h000)
    else $error("control word not zero after reset");
endmodule : ascp_top

// ==== ascp_host_model.sv ====
// host serial port model: makes serial clock, both frame syncs and data in
// assumes clk_i is the bench clock; link clock stands high outside frames
`timescale 1ns/100ps
module ascp_host_model (
  input  wire logic clk_i,                // bench clock, paces the link
  output logic      sclk_o,               // serial clock, host made
  output logic      control_frame_sync_o, // idles high
  output logic      read_frame_sync_o,    // idles low, per-device select
  output logic      sdi_o,                // serial data to the device
  input  wire logic sdo_i,                // serial data from the device
  input  wire logic sdo_oe_n_i            // low while the device drives
);
  initial
  begin
    sclk_o = 1'b1;
    control_frame_sync_o = 1'b1;
    read_frame_sync_o = 1'b0;
    sdi_o = 1'b0;
  end
  // wait n bench clocks; 8 clocks make one 400 ns link period
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_i);
  endtask : ticks
  // write frame: word msb first, then 3 spare bits the device must drop
  task automatic write_word(input logic [9:0] word, input logic [2:0] spare);
    logic [12:0] bits;
    bits = {word, spare};
    control_frame_sync_o <= 1'b0;
    for (int i = 12; i >= 0; i--) // 13 clocks per write
    begin
      sclk_o <= 1'b1;
      sdi_o  <= bits[i]; // moves on the rise, away from sampling
      ticks(4);
      sclk_o <= 1'b0;
      ticks(4);
    end
    sclk_o <= 1'b1;
    ticks(4);
    control_frame_sync_o <= 1'b1;
    sdi_o <= ~sdi_o; // released: inverse, so a stale bit cannot pass
    ticks(4); // frame sync must be seen high before the next write opens
  endtask : write_word
  // read frame: 11 rises, bit sampled late in the high phase
  task automatic read_word(output logic [9:0] data, output int driven,
                           output logic released);
    data = 10'h000;
    driven = 0;
    read_frame_sync_o <= 1'b1;
    ticks(4);
    for (int i = 9; i >= -1; i--)
    begin
      sclk_o <= 1'b0;
      ticks(3);
      sclk_o <= 1'b1;
      ticks(5);
      if (i >= 0)
      begin
        // a released pin shows the inverse, so a stale bit cannot pass
        data[i] = (sdo_oe_n_i === 1'b0) ? sdo_i : ~sdo_i;
        if (sdo_oe_n_i === 1'b0)
          driven++;
      end
    end
    released = sdo_oe_n_i;
    read_frame_sync_o <= 1'b0;
    ticks(4);
  endtask : read_word
  // free-running clock with no frame open; counts cycles seen driven
  task automatic free_clocks(input int n, output int driven);
    driven = 0;
    repeat (n)
    begin
      sclk_o <= 1'b0;
      ticks(3);
      sclk_o <= 1'b1;
      ticks(5);
      if (sdo_oe_n_i === 1'b0)
        driven++;
    end
  endtask : free_clocks
endmodule : ascp_host_model

// ==== tb.sv ====
// self-checking bench for the serial control port
// assumes 20 MHz clock, host model on the link, wishbone master tasks here
`timescale 1ns/100ps
module tb;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        sclk, cfs, read_frame_sync, sdi, trig_i, pin_i, sdo_o, sdo_oe_n_o, hold_o;
  logic [9:0]  adc_result_i, ctrl_word_o;
  logic [1:0]  pwr_state_o;
  int          err_total, check_count, cycle_count;

  ascp_top u_ascp_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sclk_i(sclk),
    .control_frame_sync_i(cfs), .read_frame_sync_i(read_frame_sync), .sdi_i(sdi),
    .conversion_trigger_i(trig_i), .package_address_select_i(pin_i), .sdo_o(sdo_o),
    .sdo_oe_n_o(sdo_oe_n_o), .adc_result_i(adc_result_i), .ctrl_word_o(ctrl_word_o),
    .pwr_state_o(pwr_state_o), .hold_o(hold_o));
  ascp_host_model u_ascp_host_model (.clk_i(clk_i), .sclk_o(sclk),
    .control_frame_sync_o(cfs), .read_frame_sync_o(read_frame_sync), .sdi_o(sdi),
    .sdo_i(sdo_o), .sdo_oe_n_i(sdo_oe_n_o));

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // hang guard: a few thousand cycles needed, ceiling well above
  always @(posedge clk_i)
  begin
    cycle_count++;
    if (cycle_count == 20000)
    begin
      err_total++;
      final_report();
    end
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : chk
  // classic single cycle; held until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                         output logic [31:0] rd);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    wb_sel_i <= 4'hf;
    // no cycle count assumed; only the hang guard ends this wait
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb_xfer
  // bounded wait for the hold output to reach a level
  task automatic wait_hold(input logic v, input int lim, input string what);
    int n;
    n = 0;
    while (hold_o !== v && n < lim)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(what, {31'h0000_0000, v}, {31'h0000_0000, hold_o});
  endtask : wait_hold
  // trigger fall, then leave the pin at lvl through end of conversion
  task automatic convert(input logic lvl, input logic [9:0] value);
    trig_i <= 1'b1;
    adc_result_i <= value;
    repeat (4) @(posedge clk_i);
    trig_i <= 1'b0;
    wait_hold(1'b1, 20, "hold on trigger fall");
    trig_i <= lvl;
    wait_hold(1'b0, 100, "conversion end");
    repeat (4) @(posedge clk_i);
    chk("edge not level", 32'h0000_0000, {31'h0000_0000, hold_o});
  endtask : convert

  initial
  begin
    logic [31:0] rd;
    logic [9:0]  res, w, val;
    logic [1:0]  pd, expp;
    logic        rel, lvl;
    int          drv;
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, trig_i, pin_i} = 6'h21;
    trig_i = 1'b1;
    pin_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    adc_result_i = 10'h000;
    err_total = 0;
    check_count = 0;
    cycle_count = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("word at reset", 32'h0000_0000, {22'h00_0000, ctrl_word_o});
    chk("power at reset", 32'h0000_0000, {30'h0000_0000, pwr_state_o});
    wb_xfer(1'b0, ascp_pkg::REG_CONFIG, 32'h0000_0000, rd);
    chk("config at reset", 32'h0000_0000, rd);
    u_ascp_host_model.free_clocks(6, drv);
    chk("drive without frame", 32'h0000_0000, drv);
    $display("test reset and idle clock done");
    // every power code against both trigger levels at conversion end
    for (int i = 0; i < 8; i++)
    begin
      pd = 2'(i >> 1);
      lvl = i[0];
      w = {2'h0, pd, 5'h00, 1'b1}; // external reference select set
      val = 10'h2d1 ^ 10'(i * 73);
      u_ascp_host_model.write_word(w, 3'h5);
      chk("accepted word", {22'h00_0000, w}, {22'h00_0000, ctrl_word_o});
      convert(lvl, val);
      case (pd)
        2'h3:    expp = ascp_pkg::PWR_UP;
        2'h0:    expp = ascp_pkg::PWR_FULL;
        2'h1:    expp = lvl ? ascp_pkg::PWR_UP : ascp_pkg::PWR_PARTIAL;
        default: expp = lvl ? ascp_pkg::PWR_UP : ascp_pkg::PWR_FULL;
      endcase
      chk("power at end", {30'h0, expp}, {30'h0, pwr_state_o});
      u_ascp_host_model.read_word(res, drv, rel);
      chk("result msb first", {22'h00_0000, val}, {22'h00_0000, res});
      chk("bits driven", 32'h0000_000a, drv);
      chk("release at rise 11", 32'h0000_0001, {31'h0, rel});
    end
    $display("test power codes and reads done");
    // address mismatch: word dropped, device stays off the bus
    u_ascp_host_model.write_word({2'h1, 2'h3, 6'h01}, 3'h2);
    chk("mismatch dropped", {22'h0, w}, {22'h0, ctrl_word_o});
    u_ascp_host_model.read_word(res, drv, rel);
    chk("deselected drive", 32'h0000_0000, drv);
    u_ascp_host_model.write_word({2'h0, 2'h3, 6'h01}, 3'h7);
    // two results buffered, read back in order
    convert(1'b1, 10'h1e7);
    convert(1'b1, 10'h218);
    u_ascp_host_model.read_word(res, drv, rel);
    chk("first buffered", 32'h0000_01e7, {22'h0, res});
    u_ascp_host_model.read_word(res, drv, rel);
    chk("second buffered", 32'h0000_0218, {22'h0, res});
    $display("test select and buffer done");
    // register bus: status, software start, unmapped place
    wb_xfer(1'b0, ascp_pkg::REG_STATUS, 32'h0000_0000, rd);
    chk("status power", {30'h0, ascp_pkg::PWR_UP}, {30'h0, rd[1:0]});
    adc_result_i <= 10'h0f0;
    wb_xfer(1'b1, ascp_pkg::REG_SWCTRL, 32'h0000_0001, rd);
    wait_hold(1'b1, 20, "software start");
    wait_hold(1'b0, 100, "software end");
    u_ascp_host_model.read_word(res, drv, rel);
    chk("software result", 32'h0000_00f0, {22'h0, res});
    wb_xfer(1'b0, 8'h0c, 32'h0000_0000, rd);
    chk("unmapped read", 32'h0000_0000, rd);
    // address pin high: only words with the address bit set are taken
    pin_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    u_ascp_host_model.write_word({2'h1, 2'h3, 6'h03}, 3'h0);
    chk("pin high match", 32'h0000_01c3, {22'h0, ctrl_word_o});
    u_ascp_host_model.write_word({2'h0, 2'h3, 6'h05}, 3'h0);
    chk("pin high mismatch", 32'h0000_01c3, {22'h0, ctrl_word_o});
    $display("test registers and address pin done");
    final_report();
  end
endmodule : tb
